// ==== hw/pwm_defines.svh ====
// Purpose: Offsets, field positions, reset values and encodings for the
//          compare array PWM block.
// Assumes: Included by its bare name after the package.
// Notes:   The numbers live here once; the package holds the types.
// Function
// RULE1: Channel is PWM when compare select is 1 and action field is 10x.
// RULE2: Each PWM channel picks inverting or non-inverting polarity.
// RULE3: Edge mode: count mode 01 counts BOTTOM up to TOP, then restarts.
// RULE4: Edge non-inverting: high on match, low at BOTTOM; inverting swapped.
// RULE5: Edge mode loads period and compare copies only at TOP overflow.
// RULE6: Edge mode: compare at or above TOP constant low, zero constant high.
// RULE7: Edge period is period value plus one counts of prescale plus one.
// RULE8: Center mode 1x counts MIN up to TOP and back, TOP one count.
// RULE9: Center non-inverting: low on up match, high on down match.
// RULE10: Center mode loads the period copy only at underflow.
// RULE11: Center period is twice the period value in counts.
// RULE12: Center mode: compare at or above TOP constant high, zero low.
// RULE13: Mode 10 loads compare and raises overflow flag at underflow only.
// RULE14: Mode 11 loads compare and raises overflow flag at underflow and TOP.
// RULE15: Phase field selects off, 1of2, 1of3, 1of4, 2of4 one-hot gating.
// RULE16: A gated channel acts as if its compare value equalled TOP.
// RULE17: Direction bit 0 steps forward, 1 reverse; changes accepted anytime.
// RULE18: Non-PWM channels are not gated but keep their shift slot.
// RULE19: Software changes the phase field only while the timer is stopped.
// RULE20: C and D in 1of2 and D in 1of3 run as ungated PWM.
// RULE21: Every compare output is 1 after reset.
// RULE22: A channel match sets its sticky event flag until software clears.
// RULE23: The one-hot register steps once per PWM period at its boundary.
`ifndef PWM_DEFINES_SVH
`define PWM_DEFINES_SVH

// Register byte offsets.
`define OFS_CTRL     8'h00
`define OFS_PERIOD   8'h04
`define OFS_TIMER    8'h08
`define OFS_FLAGS    8'h0c
`define OFS_CHAN0    8'h10
`define OFS_CHAN_LAST 8'h1c

// Field positions.
`define CTRL_W       13
`define CHAN_W       20
`define FLAG_OVF     4
`define TIMER_DIR    16

// Reset values.
`define CTRL_RST     13'h0000
`define CHAN_RST     20'h00000
`define PERIOD_RST   16'hffff
`define PHASE_RST    4'h1
`define PIN_RST      4'hf

// Encodings.
`define MODE_EDGE    2'b01
`define PWM_ACTION   2'b10
`define PHS_OFF      3'b000
`define PHS_1OF2     3'b001
`define PHS_1OF3     3'b010
`define PHS_1OF4     3'b011
`define PHS_2OF4     3'b100

`endif

// ==== hw/pwm_pkg.sv ====
// Purpose: Types shared by the compare array PWM block.
// Assumes: Nothing beyond the defines header.
// Notes:   Struct layouts match the register word bit order.
package pwm_pkg;

  // Control register layout, run bit in bit 0.
  typedef struct packed {
    logic [3:0] timer_prescale;
    logic       phase_direction_bit;
    logic [2:0] phase_mode_field;
    logic       up_down_count_enable;
    logic       timer_capture_reload_select;
    logic [1:0] timer_count_mode;
    logic       timer_run_bit;
  } ctrl_t;

  // Channel register layout, value in the low half.
  typedef struct packed {
    logic [2:0]  channel_action_field;
    logic        channel_compare_select;
    logic [15:0] channel_value;
  } chan_cfg_t;

  typedef logic [3:0] pin_vec_t;

endpackage

// ==== hw/compare_array_pwm.sv ====
// Purpose: Four-channel PWM compare array on a shared 16-bit timer,
//          reached over AHB-Lite.
// Assumes: hclk at 20 MHz; single word transfers; no wait states.
// Notes:   Action field bit 0 selects the inverting polarity.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_defines.svh"

module compare_array_pwm (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  output pwm_pkg::pin_vec_t channel_output_pin
);
  import pwm_pkg::*;

  // Rotates the one-hot register inside a ring of len positions.
  function automatic logic [3:0] step_ring(input logic [3:0] ph,
                                           input logic [2:0] len,
                                           input logic       rev);
    logic [3:0] top_bit;
    logic [3:0] res;
    top_bit = 4'h1 << (len - 3'd1);
    // Compared one bit wider so the four-long ring does not shift out.
    if (ph == 4'h0 || {1'b0, ph} >= ({1'b0, top_bit} << 1)) begin
      res = `PHASE_RST;
    end else if (!rev) begin
      res = (ph == top_bit) ? 4'h1 : (ph << 1);
    end else begin
      res = (ph == 4'h1) ? top_bit : (ph >> 1);
    end
    return res;
  endfunction

  // Bus side state.
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic [31:0] hrdata_ff;
  // Software-visible registers.
  ctrl_t       ctrl_ff;
  logic [15:0] period_buf_ff;
  chan_cfg_t   chan_ff [4];
  logic [3:0]  evt_flag_ff;
  logic        ovf_flag_ff;
  // Timer and active copies.
  logic [3:0]  pre_ff;
  logic [15:0] cnt_ff;
  logic        down_ff;
  logic [15:0] top_ff;
  logic [15:0] cmp_ff [4];
  logic [3:0]  phase_ff;
  logic [3:0]  pin_ff;

  // Address phase decode and register selection.
  wire       take      = hsel & hready & htrans[1];
  wire [7:0] rd_ofs    = haddr[7:0];
  wire       rd_chan   = rd_ofs >= `OFS_CHAN0 && rd_ofs <= `OFS_CHAN_LAST;
  wire [1:0] rd_idx    = rd_ofs[3:2];
  wire       wr_now    = wr_pend_ff;
  wire       wr_ctrl   = wr_now && wr_addr_ff == `OFS_CTRL;
  wire       wr_period = wr_now && wr_addr_ff == `OFS_PERIOD;
  wire       wr_flags  = wr_now && wr_addr_ff == `OFS_FLAGS;
  wire       wr_chan   = wr_now && wr_addr_ff >= `OFS_CHAN0
                         && wr_addr_ff <= `OFS_CHAN_LAST;
  wire [1:0] wr_idx    = wr_addr_ff[3:2];
  wire [3:0] evt_clr   = wr_flags ? hwdata[3:0] : 4'h0;
  wire       ovf_clr   = wr_flags & hwdata[`FLAG_OVF];

  // Read mux; unmapped offsets read zero.
  logic [31:0] rd_word;
  assign rd_word =
      (rd_ofs == `OFS_CTRL)   ? {19'h0, ctrl_ff} :
      (rd_ofs == `OFS_PERIOD) ? {16'h0, period_buf_ff} :
      (rd_ofs == `OFS_TIMER)  ? {15'h0, down_ff, cnt_ff} :
      (rd_ofs == `OFS_FLAGS)  ? {27'h0, ovf_flag_ff, evt_flag_ff} :
      rd_chan                 ? {12'h0, chan_ff[rd_idx]} : 32'h0;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  // Timer prescale tick and count control.
  wire        run    = ctrl_ff.timer_run_bit;
  wire        center = ctrl_ff.timer_count_mode[1];
  wire        tick   = run && pre_ff == ctrl_ff.timer_prescale; // RULE7
  wire [15:0] cnt_up = cnt_ff + 16'h1;
  wire [15:0] cnt_dn = cnt_ff - 16'h1;
  wire        wrap   = tick & ~center & (cnt_ff >= top_ff);
  wire        unfl   = tick & center & down_ff & (cnt_ff <= 16'h1);
  wire        at_top = tick & center & ~down_ff & (cnt_up >= top_ff)
                       & (cnt_ff < top_ff);
  wire        phs_md = ctrl_ff.timer_count_mode == 2'b11;
  // Period boundary, and compare loading per count mode.
  wire        boundary = wrap | unfl; // RULE23
  wire        load_cmp = wrap | unfl | (at_top & phs_md); // RULE5 RULE13 RULE14
  wire        ovf_evt  = wrap | unfl | (at_top & phs_md); // RULE13 RULE14
  wire        pwm_tmr  = ~ctrl_ff.timer_capture_reload_select
                         & ~ctrl_ff.up_down_count_enable;

  // Next timer value for single and dual slope counting.
  logic [15:0] nxt_cnt;
  logic        nxt_down;
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_down = down_ff;
    if (tick) begin
      if (!center) begin
        nxt_cnt  = (cnt_ff >= top_ff) ? 16'h0 : cnt_up; // RULE3
        nxt_down = 1'b0;
      end else if (!down_ff) begin
        if (cnt_ff >= top_ff) begin
          nxt_cnt  = (top_ff == 16'h0) ? 16'h0 : cnt_dn; // RULE8
          nxt_down = top_ff != 16'h0;
        end else begin
          nxt_cnt = cnt_up;
        end
      end else begin
        nxt_cnt  = (cnt_ff <= 16'h1) ? 16'h0 : cnt_dn; // RULE8
        nxt_down = cnt_ff > 16'h1;
      end
    end
  end

  // Multi-phasic ring length and per-channel gate.
  logic [2:0] ring_len;
  logic [3:0] gate_en;
  assign ring_len =
      (ctrl_ff.phase_mode_field == `PHS_1OF3) ? 3'd3 :
      (ctrl_ff.phase_mode_field == `PHS_1OF4) ? 3'd4 : 3'd2; // RULE15
  assign gate_en =
      (ctrl_ff.phase_mode_field == `PHS_1OF2) ? {2'b11, phase_ff[1:0]} :
      (ctrl_ff.phase_mode_field == `PHS_1OF3) ? {1'b1, phase_ff[2:0]} :
      (ctrl_ff.phase_mode_field == `PHS_1OF4) ? phase_ff :
      (ctrl_ff.phase_mode_field == `PHS_2OF4) ?
          {phase_ff[1:0], phase_ff[1:0]} : 4'hf; // RULE15 RULE20
  wire phase_on = ctrl_ff.phase_mode_field != `PHS_OFF;

  // Per-channel compare decisions.
  logic [3:0] is_pwm;
  logic [3:0] inv;
  logic [3:0] match;
  logic [3:0] nxt_pin;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_ch
      wire        sel   = chan_ff[g].channel_compare_select;
      wire [2:0]  act   = chan_ff[g].channel_action_field;
      wire [15:0] cmp   = cmp_ff[g];
      wire        blk   = ~gate_en[g]; // RULE16
      wire        full  = blk | (cmp >= top_ff); // RULE16
      wire        zero  = ~blk & (cmp == 16'h0);
      wire        inner = ~full & ~zero;
      assign is_pwm[g] = sel & (act[2:1] == `PWM_ACTION); // RULE1
      assign inv[g]    = act[0]; // RULE2
      assign match[g]  = tick & sel & (cnt_ff == cmp);
      always_comb begin
        nxt_pin[g] = pin_ff[g];
        if (tick & is_pwm[g] & pwm_tmr) begin
          if (!center) begin
            // Level for the new period, then the match in it.
            if (cnt_ff == 16'h0) begin
              nxt_pin[g] = (zero) ? ~inv[g] : inv[g]; // RULE4 RULE6
            end else if (inner & (cnt_ff == cmp)) begin
              nxt_pin[g] = ~inv[g]; // RULE4
            end
          end else begin
            if (cnt_ff == 16'h0 && !inner) begin
              nxt_pin[g] = full ? ~inv[g] : inv[g]; // RULE12
            end else if (inner & (cnt_ff == cmp)) begin
              nxt_pin[g] = down_ff ? ~inv[g] : inv[g]; // RULE9
            end
          end
        end
      end
    end
  endgenerate

  // Bus data phase capture and read data.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h0;
    end else if (hready) begin
      wr_pend_ff <= take & hwrite;
      wr_addr_ff <= haddr[7:0];
      hrdata_ff  <= (take & ~hwrite) ? rd_word : 32'h0;
    end
  end

  // Control, period buffer and channel registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff       <= `CTRL_RST;
      period_buf_ff <= `PERIOD_RST;
      for (int i = 0; i < 4; i++) begin
        chan_ff[i] <= `CHAN_RST;
      end
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= hwdata[`CTRL_W-1:0]; // RULE17
      end
      if (wr_period) begin
        period_buf_ff <= hwdata[15:0];
      end
      if (wr_chan) begin
        chan_ff[wr_idx] <= hwdata[`CHAN_W-1:0];
      end
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_flag_ff <= 4'h0;
      ovf_flag_ff <= 1'b0;
    end else begin
      evt_flag_ff <= (evt_flag_ff & ~evt_clr) | match; // RULE22
      ovf_flag_ff <= (ovf_flag_ff & ~ovf_clr) | ovf_evt; // RULE13 RULE14
    end
  end

  // Prescaler and timer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_ff  <= 4'h0;
      cnt_ff  <= 16'h0;
      down_ff <= 1'b0;
    end else begin
      pre_ff  <= (!run || tick) ? 4'h0 : pre_ff + 4'h1; // RULE7 RULE11
      cnt_ff  <= nxt_cnt;
      down_ff <= nxt_down;
    end
  end

  // Active period and compare copies, loaded at the period boundaries; mode 11 also loads the compares at TOP.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      top_ff <= `PERIOD_RST;
      for (int i = 0; i < 4; i++) begin
        cmp_ff[i] <= 16'h0;
      end
    end else begin
      if (boundary) begin
        top_ff <= period_buf_ff; // RULE5 RULE10
      end
      if (load_cmp) begin
        for (int i = 0; i < 4; i++) begin
          cmp_ff[i] <= chan_ff[i].channel_value; // RULE5 RULE13 RULE14
        end
      end
    end
  end

  // One-hot phase ring, stepped once per period while gating is on.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_ff <= `PHASE_RST;
    end else if (boundary & phase_on) begin
      phase_ff <= step_ring(phase_ff, ring_len,
                            ctrl_ff.phase_direction_bit); // RULE17 RULE23 RULE18
    end
  end

  // Output pins, all high out of reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_ff <= `PIN_RST; // RULE21
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  assign channel_output_pin = pin_ff;

endmodule // compare_array_pwm
`default_nettype wire

// ==== verif/compare_array_pwm_assertions.sv ====
// Purpose: Port assertions for the compare array PWM block.
// Assumes: Word transfers only; CTRL is mirrored from bus writes.
// Notes:   Bound to every compare_array_pwm instance.
`timescale 1ns/1ns
`default_nettype none
module pwm_checker (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata,
  input wire pwm_pkg::pin_vec_t channel_output_pin
);
  import pwm_pkg::*;
  logic       wr_ff;
  logic       rd_ff;
  logic [7:0] adr_ff;
  ctrl_t      ctrl_ff;
  wire        take = hsel && hready && htrans[1];
  wire        ctrl_wr = wr_ff && (adr_ff == 8'h00);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Mirrors the address phase and the control word that software wrote.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff   <= 1'b0;
      rd_ff   <= 1'b0;
      adr_ff  <= 8'h00;
      ctrl_ff <= '0;
    end else begin
      wr_ff  <= take && hwrite;
      rd_ff  <= take && !hwrite;
      adr_ff <= haddr[7:0];
      if (ctrl_wr) ctrl_ff <= ctrl_t'(hwdata[12:0]);
    end
  end
  // Bus answers, reset levels and pin timing against the mirrored control.
  AST_PIN_RESET: assert property ($rose(hresetn) |->
    channel_output_pin == 4'hf) else $error("pins not high after reset");
  AST_READY_HIGH: assert property (hreadyout)
    else $error("wait state inserted");
  AST_RESP_OKAY: assert property (!hresp) else $error("error response");
  AST_RDATA_IDLE: assert property (!rd_ff |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  AST_CTRL_BACK: assert property (rd_ff && adr_ff == 8'h00 |->
    hrdata[12:0] == ctrl_ff) else $error("control read back differs");
  AST_STOP_HOLD: assert property (!ctrl_ff.timer_run_bit ||
    ctrl_ff.timer_capture_reload_select || ctrl_ff.up_down_count_enable
    |=> $stable(channel_output_pin)) else $error("pins moved while idle");
  AST_EDGE_UP: assert property (rd_ff && adr_ff == 8'h08 &&
    ctrl_ff.timer_count_mode == 2'b01 |-> !hrdata[16])
    else $error("single slope timer counting down");
  AST_PRESCALE: assert property (ctrl_ff.timer_run_bit &&
    ctrl_ff.timer_prescale != 4'h0 && $changed(channel_output_pin)
    |=> $stable(channel_output_pin)) else $error("pins faster than tick");
endmodule // pwm_checker
bind compare_array_pwm pwm_checker chk_u (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
  .channel_output_pin);
`default_nettype wire

// ==== verif/pwm_load.sv ====
// Purpose: Load on the four PWM pins that tallies their high cycles.
// Assumes: One sample per rising edge of hclk.
// Notes:   clr restarts every tally.
`timescale 1ns/1ns
`default_nettype none
module pwm_load (
  input  wire logic              hclk,
  input  wire logic              clr,
  input  wire pwm_pkg::pin_vec_t pin,
  output logic [3:0][7:0]        hi_cnt
);
  import pwm_pkg::*;
  // Each tally grows by one for every sampled high cycle of its pin.
  always_ff @(posedge hclk) begin
    for (int i = 0; i < 4; i++) begin
      hi_cnt[i] <= clr ? 8'h00 : hi_cnt[i] + {7'h0, pin[i]};
    end
  end
endmodule // pwm_load
`default_nettype wire

// ==== verif/testbench.sv ====
// Purpose: Directed bench for the compare array PWM block.
// Assumes: AHB-Lite single word transfers.
// Notes:   High-time tallies come from the pin load model.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin \
  n_fail++; $display("mismatch %s exp %h got %h", nm, e, s); end end
module testbench;
  import pwm_pkg::*;
  logic            hclk, hresetn, hsel, hwrite, clr;
  logic [31:0]     haddr, hwdata, hrdata, q;
  logic [1:0]      htrans;
  wire             hreadyout, hresp;
  pin_vec_t        pin;
  logic [3:0][7:0] cnt;
  int              n_fail, cmp_count;
  logic [31:0]     cv [4] = '{32'h90001, 32'hb0001, 32'h90000, 32'h90005};
  logic [12:0]     row [6] = '{13'h203, 13'h23, 13'h143, 13'h63, 13'h163,
                               13'h183};
  logic [31:0]     tally [6] = '{32'h300c24, 32'h301e12, 32'h10240c,
                                 32'h0c2709, 32'h0c2709, 32'h181e12};
  compare_array_pwm dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .channel_output_pin(pin));
  pwm_load load_u (.hclk, .clr, .pin, .hi_cnt(cnt));
  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Steps to the next edge at which the slave is ready, within a bound.
  task automatic edge_rdy();
    @(posedge hclk);
    for (int n = 0; hreadyout !== 1'b1; n++) begin
      if (n == 50) begin
        n_fail++;
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask
  // One AHB-Lite single transfer; read data lands in q.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    edge_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    edge_rdy();
    q = hrdata;
  endtask
  // Waits for a high then a low on one pin, within a bound.
  task automatic wt(input int i);
    for (int n = 0; pin[i] !== 1'b1 || n == 0; n++) begin
      if (n == 70000) begin
        n_fail++;
        print_verdict();
      end
      @(negedge hclk);
    end
    for (int n = 0; pin[i] !== 1'b0; n++) begin
      if (n == 70000) begin
        n_fail++;
        print_verdict();
      end
      @(negedge hclk);
    end
  endtask
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // Main sequence: reset, single slope, dual slope, then phase gating.
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    clr = 1'b1;
    n_fail = 0;
    cmp_count = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    `CHK("pins", 4'hf, pin)
    @(posedge hclk);
    xfer(0, 8'h04, 0);
    `CHK("period", 32'hffff, q)
    xfer(0, 8'h20, 0);
    `CHK("unmapped", 32'h0, q)
    xfer(1, 8'h04, 32'h3);
    for (int i = 0; i < 4; i++) xfer(1, 8'h10 + 8'(4 * i), cv[i]);
    xfer(1, 8'h00, 32'h3);
    wt(3);
    for (int k = 0; k < 8; k++) begin
      `CHK("edge", (k % 4 == 0) ? 4'h6 : 4'h5, pin)
      @(negedge hclk);
    end
    @(posedge hclk);
    xfer(0, 8'h08, 0);
    `CHK("timer_up", 1'b0, q[16] | (q[15:0] > 16'h3))
    xfer(1, 8'h00, 32'h102);
    xfer(0, 8'h00, 0);
    `CHK("ctrl", 32'h102, q)
    xfer(0, 8'h0c, 0);
    `CHK("flags", 32'h1f, q)
    xfer(1, 8'h0c, 32'h1f);
    xfer(0, 8'h0c, 0);
    `CHK("flags_clr", 32'h0, q)
    for (int m = 5; m <= 7; m += 2) begin
      xfer(1, 8'h00, 32'(m));
      wt(0);
      for (int k = 0; k < 12; k++) begin
        `CHK("center", (k % 6 < 4) ? 4'ha : 4'h9, pin)
        @(negedge hclk);
      end
      @(posedge hclk);
      xfer(0, 8'h0c, 0);
      `CHK("ovf", 1'b1, q[4])
      xfer(1, 8'h00, 32'(m - 1));
      xfer(1, 8'h0c, 32'h10);
    end
    for (int r = 0; r < 6; r++) begin
      xfer(1, 8'h00, {19'h0, row[r] & 13'h1ffe});
      xfer(1, 8'h00, {19'h0, row[r]});
      repeat (32) @(posedge hclk);
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      repeat (48) @(posedge hclk);
      @(negedge hclk);
      `CHK("tally", tally[r], cnt)
      @(posedge hclk);
      xfer(1, 8'h00, {19'h0, row[r] & 13'h1ffe});
    end
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
